// file: rios_flash.sv
// flash pattern generator driven by a shared tick
`timescale 1ns/100ps
module rios_flash
   import rios_pkg::*;
#(
   parameter rios_pat_e PATTERN = RIOS_PAT_CONT
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // control
   input  wire logic tick,
   input  wire logic enable,
   // lamp
   output logic      lamp_ff
);
   import rios_pkg::*;

   localparam logic [TK_W-1:0] ON_TK  = TK_W'(FLASH_ON_TK);
   localparam logic [TK_W-1:0] OFF_TK = TK_W'(FLASH_OFF_TK);
   localparam logic [TK_W-1:0] GAP_TK = TK_W'(DOUBLE_GAP_TK);
   localparam logic [TK_W-1:0] SOF_TK = TK_W'(SINGLE_OFF_TK);
   localparam logic [TK_W-1:0] DOF_TK = TK_W'(DOUBLE_OFF_TK);

   // first lit phase, dark gap, second lit phase (double only), long dark (double only)
   typedef enum logic [3:0] {
      RIOS_PH_LIT1 = 4'h1,
      RIOS_PH_GAP  = 4'h2,
      RIOS_PH_LIT2 = 4'h4,
      RIOS_PH_DARK = 4'h8
   } rios_phase_e;

   rios_phase_e     phase_ff;
   logic [TK_W-1:0] cnt_ff;
   rios_phase_e     nxt_phase;
   logic [TK_W-1:0] limit;
   wire             phase_end = tick && (cnt_ff >= limit - TK_W'(1));

   always_comb begin
      limit     = ON_TK;
      nxt_phase = RIOS_PH_LIT1;
      unique case (phase_ff)
         RIOS_PH_LIT1: begin
            limit     = ON_TK;
            nxt_phase = RIOS_PH_GAP;
         end
         RIOS_PH_GAP: begin
            limit     = (PATTERN == RIOS_PAT_CONT) ? OFF_TK :
                        (PATTERN == RIOS_PAT_SINGLE) ? SOF_TK : GAP_TK;
            nxt_phase = (PATTERN == RIOS_PAT_DOUBLE) ? RIOS_PH_LIT2 : RIOS_PH_LIT1;
         end
         RIOS_PH_LIT2: begin
            limit     = ON_TK;
            nxt_phase = RIOS_PH_DARK;
         end
         RIOS_PH_DARK: begin
            limit     = DOF_TK;
            nxt_phase = RIOS_PH_LIT1;
         end
         default: begin
            limit     = ON_TK;
            nxt_phase = RIOS_PH_LIT1;
         end
      endcase
   end

   // restart from a lit phase so a newly selected pattern shows at once
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         phase_ff <= RIOS_PH_LIT1;
         cnt_ff   <= '0;
         lamp_ff  <= 1'b0;
      end else if (!enable) begin
         phase_ff <= RIOS_PH_LIT1;
         cnt_ff   <= '0;
         lamp_ff  <= 1'b0;
      end else begin
         lamp_ff <= (phase_ff == RIOS_PH_LIT1) || (phase_ff == RIOS_PH_LIT2);
         if (phase_end) begin
            cnt_ff   <= '0;
            phase_ff <= nxt_phase;
         end else if (tick) begin
            cnt_ff <= cnt_ff + TK_W'(1);
         end
      end
   end

endmodule

// file: rios_master.sv
// partner model: fieldbus master state and link fault reporting
`timescale 1ns/100ps
module rios_master
   import rios_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // scenario commands
   input  wire rios_bus_e  go_state,
   input  wire logic [1:0] go_fault,
   // link status towards the block
   output rios_bus_e       bus_state_ff,
   output logic            link_down_ff,
   output logic            conn_error_ff
);
   import rios_pkg::*;

   // registered so every change lands one edge after the command
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bus_state_ff  <= RIOS_ST_INIT;
         link_down_ff  <= 1'b0;
         conn_error_ff <= 1'b0;
      end else begin
         bus_state_ff  <= go_state;
         link_down_ff  <= go_fault[0];
         conn_error_ff <= go_fault[1];
      end
   end
endmodule

// file: rios_pkg.sv
// package: constants and types for the remote i/o status indicator block
package rios_pkg;

   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned CHAN_COUNT    = 16;

   // flash base tick period, and pattern lengths counted in ticks
   localparam int unsigned TICK_NS       = 50_000_000;
   localparam int unsigned TICK_CYCLES   = (TICK_NS / 20 > 0) ? TICK_NS / 20 : 1;
   localparam int unsigned FLASH_ON_TK   = 4;
   localparam int unsigned FLASH_OFF_TK  = 4;
   localparam int unsigned SINGLE_OFF_TK = 20;
   localparam int unsigned DOUBLE_GAP_TK = 4;
   localparam int unsigned DOUBLE_OFF_TK = 20;
   localparam int unsigned TK_W          = 6;

   // port direction variants
   typedef enum logic [1:0] {
      RIOS_DIR_IN_OUT  = 2'h0,
      RIOS_DIR_IN_IN   = 2'h1,
      RIOS_DIR_OUT_OUT = 2'h2
   } rios_dir_e;

   // fieldbus state machine state as reported by the link controller
   typedef enum logic [3:0] {
      RIOS_ST_INIT   = 4'h1,
      RIOS_ST_PREOP  = 4'h2,
      RIOS_ST_SAFEOP = 4'h4,
      RIOS_ST_OP     = 4'h8
   } rios_bus_e;

   typedef enum logic [2:0] {
      RIOS_PAT_CONT   = 3'h0,
      RIOS_PAT_SINGLE = 3'h1,
      RIOS_PAT_DOUBLE = 3'h2
   } rios_pat_e;

   typedef struct packed {
      logic [15:0] port0;
      logic [15:0] port1;
   } rios_chan_s;

   typedef struct packed {
      logic run_lamp;
      logic err_lamp;
   } rios_stat_s;

   // interrupt status bit positions
   localparam int unsigned IRQ_STATE_CHG = 0;
   localparam int unsigned IRQ_FAULT_ON  = 1;
   localparam int unsigned IRQ_W         = 2;

endpackage

// file: rios_top.sv
// remote i/o status indicators: channel lamps, run lamp, fault lamp, interrupt
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps

module rios_top
   import rios_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // variant and controller-side channel activation
   input  wire rios_dir_e   port_dir,
   input  wire rios_chan_s  ctrl_in_act,
   input  wire rios_chan_s  ctrl_out_act,
   // fieldbus status
   input  wire rios_bus_e   bus_state,
   input  wire logic        link_down,
   input  wire logic        conn_error,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata_ff,
   // lamps and interrupt
   output rios_chan_s       chan_lamp_ff,
   output logic             run_green_ff,
   output logic             err_red_ff,
   output logic             irq_ff
);
   import rios_pkg::*;

   // register map: status (read), clear (write ones), enable, state readback
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_CLEAR  = 4'h4;
   localparam logic [3:0] REG_ENABLE = 4'h8;
   localparam logic [3:0] REG_STATE  = 4'hC;
   localparam logic [31:0] TICK_MAX  = 32'(TICK_CYCLES - 1);

   // shared prescaler tick; one divider keeps all patterns in step
   logic [31:0] pre_ff;
   logic        tick_ff;
   wire         pre_wrap = (pre_ff == TICK_MAX);
   wire  [31:0] nxt_pre  = pre_wrap ? 32'h0 : pre_ff + 32'h1;

   // the tick is a one-cycle enable pulse, never a second clock
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pre_ff  <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= pre_wrap;
         pre_ff  <= nxt_pre;
      end
   end

   // channel lamp source: inputs or outputs per port, per the variant
   // in_out: port0 inputs, port1 outputs; in_in: both inputs; out_out: both
   // outputs; the spare code shows inputs on both banks
   wire p0_is_out = (port_dir == RIOS_DIR_OUT_OUT);
   wire p1_is_out = (port_dir == RIOS_DIR_IN_OUT) || (port_dir == RIOS_DIR_OUT_OUT);
   wire rios_chan_s nxt_chan;

   generate
      for (genvar i = 0; i < CHAN_COUNT; i++) begin : g_chan
         // activation state only; a lamp/terminal mismatch reveals wiring faults
         wire act_in0  = ctrl_in_act.port0[i];
         wire act_out0 = ctrl_out_act.port0[i];
         wire act_in1  = ctrl_in_act.port1[i];
         wire act_out1 = ctrl_out_act.port1[i];
         assign nxt_chan.port0[i] = p0_is_out ? act_out0 : act_in0;
         assign nxt_chan.port1[i] = p1_is_out ? act_out1 : act_in1;
      end
   endgenerate

   // fieldbus state and fault decode
   wire in_preop  = (bus_state == RIOS_ST_PREOP);
   wire in_safeop = (bus_state == RIOS_ST_SAFEOP);
   wire fault     = link_down | conn_error;

   // flash generators; each restarts lit when selected, so a new state
   // shows at once instead of waiting for the next tick
   logic single_lamp;
   logic cont_lamp;
   logic double_lamp;

   rios_flash #(.PATTERN(RIOS_PAT_SINGLE)) u_single (
      .clock   (clock),
      .resetn  (resetn),
      .tick    (tick_ff),
      .enable  (in_preop),
      .lamp_ff (single_lamp)
   );
   rios_flash #(.PATTERN(RIOS_PAT_CONT)) u_cont (
      .clock   (clock),
      .resetn  (resetn),
      .tick    (tick_ff),
      .enable  (in_safeop),
      .lamp_ff (cont_lamp)
   );
   rios_flash #(.PATTERN(RIOS_PAT_DOUBLE)) u_double (
      .clock   (clock),
      .resetn  (resetn),
      .tick    (tick_ff),
      .enable  (fault),
      .lamp_ff (double_lamp)
   );

   // run lamp is green only; the single and continuous patterns land on the green output, the double goes to red
   logic nxt_run;
   always_comb begin
      nxt_run = 1'b0;
      unique case (bus_state)
         RIOS_ST_INIT:   nxt_run = 1'b0;
         RIOS_ST_PREOP:  nxt_run = single_lamp;
         RIOS_ST_SAFEOP: nxt_run = cont_lamp;
         RIOS_ST_OP:     nxt_run = 1'b1;
         default:        nxt_run = 1'b0;
      endcase
   end

   // interrupt events: a fieldbus state change and the start of a link fault
   rios_bus_e        last_state_ff;
   logic             last_fault_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_en_ff;

   wire             state_chg = (bus_state != last_state_ff);
   wire             fault_on  = fault & ~last_fault_ff;
   wire [IRQ_W-1:0] irq_event;

   assign irq_event[IRQ_STATE_CHG] = state_chg;
   assign irq_event[IRQ_FAULT_ON]  = fault_on;

   // register decode; writes to status, state or unmapped words are dropped
   wire             hit_status = (reg_addr == REG_STATUS);
   wire             hit_clear  = (reg_addr == REG_CLEAR);
   wire             hit_enable = (reg_addr == REG_ENABLE);
   wire             hit_state  = (reg_addr == REG_STATE);
   wire             wr_clear   = reg_wr && hit_clear;
   wire             wr_enable  = reg_wr && hit_enable;
   wire [IRQ_W-1:0] clr_mask   = wr_clear ? reg_wdata[IRQ_W-1:0] : '0;
   // set beats clear so a simultaneous event is never lost
   wire [IRQ_W-1:0] nxt_stat   = (irq_stat_ff & ~clr_mask) | irq_event;
   wire [IRQ_W-1:0] nxt_en     = wr_enable ? reg_wdata[IRQ_W-1:0] : irq_en_ff;
   wire             nxt_irq    = |(irq_stat_ff & irq_en_ff);

   // read words; state holds fault at bit 5, both-outputs at bit 4, bus state below
   wire [31:0] word_status = {30'h0, irq_stat_ff};
   wire [31:0] word_enable = {30'h0, irq_en_ff};
   wire [31:0] word_state  = {26'h0, fault, (port_dir == RIOS_DIR_OUT_OUT), last_state_ff};
   // clear reads as zero; idle cycles and unmapped words read zero too
   wire [31:0] nxt_rdata   = !reg_rd    ? 32'h0       :
                             hit_status ? word_status :
                             hit_enable ? word_enable :
                             hit_state  ? word_state  :
                             32'h0;

   // channel lamps follow activation one cycle late
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         chan_lamp_ff <= '0;
      end else begin
         chan_lamp_ff <= nxt_chan;
      end
   end

   // green run lamp
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         run_green_ff <= 1'b0;
      end else begin
         run_green_ff <= nxt_run;
      end
   end

   // red lamp gated by the live fault, so it drops with the fault mid-flash
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         err_red_ff <= 1'b0;
      end else begin
         err_red_ff <= fault & double_lamp;
      end
   end

   // edge history; reset values match the idle inputs, so no false event
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         last_state_ff <= RIOS_ST_INIT;
         last_fault_ff <= 1'b0;
      end else begin
         last_state_ff <= bus_state;
         last_fault_ff <= fault;
      end
   end

   // sticky status and its enable mask
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_stat_ff <= '0;
         irq_en_ff   <= '0;
      end else begin
         irq_stat_ff <= nxt_stat;
         irq_en_ff   <= nxt_en;
      end
   end

   // interrupt line is a flop, so it trails the status bit by one cycle
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_ff <= '0;
      end else begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

endmodule

// file: rios_top_chk.sv
// checker: lamp behaviour of the indicator block seen at its ports
`timescale 1ns/100ps
module rios_top_chk
   import rios_pkg::*;
(
   // clock and reset
   input wire logic       clock,
   input wire logic       resetn,
   // observed inputs
   input wire rios_dir_e  port_dir,
   input wire rios_chan_s ctrl_in_act,
   input wire rios_chan_s ctrl_out_act,
   input wire rios_bus_e  bus_state,
   input wire logic       link_down,
   input wire logic       conn_error,
   // observed outputs
   input wire rios_chan_s chan_lamp_ff,
   input wire logic       run_green_ff,
   input wire logic       err_red_ff,
   input wire logic       irq_ff
);
   import rios_pkg::*;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   lamp_in_a: assert property ($past(resetn) && port_dir == RIOS_DIR_IN_IN
      |=> chan_lamp_ff == $past(ctrl_in_act)) else $error("input lamps wrong");
   lamp_mix_a: assert property ($past(resetn) && port_dir == RIOS_DIR_IN_OUT
      |=> chan_lamp_ff == {$past(ctrl_in_act.port0), $past(ctrl_out_act.port1)})
      else $error("mixed lamps wrong");
   lamp_out_a: assert property ($past(resetn) && port_dir == RIOS_DIR_OUT_OUT
      |=> chan_lamp_ff == $past(ctrl_out_act)) else $error("output lamps wrong");
   run_op_a: assert property (bus_state == RIOS_ST_OP [*2] |=> run_green_ff)
      else $error("run lamp not solid in op");
   run_init_a: assert property (bus_state == RIOS_ST_INIT [*2] |=> !run_green_ff)
      else $error("run lamp lit in init");
   flash_start_a: assert property ($changed(bus_state)
      && bus_state inside {RIOS_ST_PREOP, RIOS_ST_SAFEOP} |-> ##[1:4] run_green_ff)
      else $error("run flash did not start lit");
   err_on_a: assert property ($rose(link_down || conn_error) |-> ##[1:4] err_red_ff)
      else $error("fault lamp did not light");
   err_off_a: assert property (!(link_down || conn_error) [*3] |=> !err_red_ff)
      else $error("fault lamp lit without fault");

   cover property (bus_state == RIOS_ST_SAFEOP && run_green_ff);
   cover property (err_red_ff && link_down);
   cover property (irq_ff);
endmodule

bind rios_top rios_top_chk u_chk (.clock(clock), .resetn(resetn), .port_dir(port_dir),
   .ctrl_in_act(ctrl_in_act), .ctrl_out_act(ctrl_out_act), .bus_state(bus_state),
   .link_down(link_down), .conn_error(conn_error), .chan_lamp_ff(chan_lamp_ff),
   .run_green_ff(run_green_ff), .err_red_ff(err_red_ff), .irq_ff(irq_ff));

// file: testbench.sv
// testbench: lamps, run and fault indicators, status registers, interrupt
`timescale 1ns/100ps
module testbench;
   import rios_pkg::*;
   logic clock = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq, err_red, run_green;
   logic link_down, conn_error;
   logic [1:0] go_fault = 2'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, rdata, exp_l;
   rios_dir_e port_dir = RIOS_DIR_IN_OUT;
   rios_bus_e go_state = RIOS_ST_INIT, bus_state;
   rios_chan_s in_act = rios_chan_s'(32'hA5A5_0F0F), out_act = rios_chan_s'(32'h1234_8001);
   rios_chan_s lamps;
   int fail_count = 0, checks_done = 0;

   always #10 clock = ~clock;

   rios_master u_master (.clock(clock), .resetn(resetn), .go_state(go_state),
      .go_fault(go_fault), .bus_state_ff(bus_state), .link_down_ff(link_down),
      .conn_error_ff(conn_error));
   rios_top u_dut (.clock(clock), .resetn(resetn), .port_dir(port_dir), .ctrl_in_act(in_act),
      .ctrl_out_act(out_act), .bus_state(bus_state), .link_down(link_down),
      .conn_error(conn_error), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_ff(rdata), .chan_lamp_ff(lamps), .run_green_ff(run_green),
      .err_red_ff(err_red), .irq_ff(irq));

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 chk("read data", rdata, e);
   endtask
   task automatic after(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic finish_test;
      if (fail_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (2000) @(posedge clock);
      fail_count++;
      finish_test();
   end

   initial begin
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      for (int d = 0; d < 3; d++) begin
         @(posedge clock);
         port_dir <= rios_dir_e'(d);
         exp_l = (d == 0) ? 32'hA5A5_8001 : (d == 1) ? 32'hA5A5_0F0F : 32'h1234_8001;
         after(3);
         chk("channel lamps", lamps, exp_l);
      end
      wr(4'h4, 32'h3);
      wr(4'h8, 32'h3);
      rd(4'h8, 32'h3);
      rd(4'h0, 32'h0);
      go_state <= RIOS_ST_OP;
      after(4);
      chk("run lamp", run_green, 1'b1);
      chk("interrupt", irq, 1'b1);
      rd(4'h0, 32'h1);
      rd(4'hC, 32'h18);
      wr(4'h4, 32'h1);
      after(2);
      chk("interrupt", irq, 1'b0);
      go_fault <= 2'h1;
      after(3);
      chk("fault lamp", err_red, 1'b1);
      rd(4'h0, 32'h2);
      wr(4'h8, 32'h0);
      after(2);
      chk("masked interrupt", irq, 1'b0);
      rd(4'hC, 32'h38);
      wr(4'h2, 32'hFF);
      rd(4'h2, 32'h0);
      rd(4'h8, 32'h0);
      go_fault <= 2'h2;
      after(4);
      chk("fault lamp", err_red, 1'b1);
      go_fault <= 2'h0;
      after(5);
      chk("fault lamp", err_red, 1'b0);
      go_state <= RIOS_ST_SAFEOP;
      after(4);
      chk("run lamp", run_green, 1'b1);
      go_state <= RIOS_ST_PREOP;
      after(4);
      chk("run lamp", run_green, 1'b1);
      go_state <= RIOS_ST_INIT;
      after(3);
      chk("run lamp", run_green, 1'b0);
      finish_test();
   end
endmodule
